// file: inc/cabc_pkg.sv
// Constants and state types of the asynchronous bus cycle sequencer.
// Notes on behaviour
// - 8-bit word write splits into byte cycles
// - S0 drives class codes, read/write high
// - Address at S1; strobe, write-low at S2
// - Write data driven during S3
// - Byte strobe at S4, then await answer
// - No answer by S4 end: wait states
// - Slow-peripheral request turns cycle over
// - Strobes off entering S7; float after S7
// - Read-modify-write holds address strobe; byte only
// - RMW read: capture, drop data strobes only
// - S8 to S11 leave bus unchanged
// - RMW write from S12; write-low at S14
// - RMW data S15, strobe S16, waits apply
// - Strobes off entering S19; float after S19
// - 16-bit strobes: word both, byte by A0
// - 16-bit address from A1, sixteen data lines
// - Width select high at reset: 16-bit
// - Width select grounded at reset: 8-bit
// - 8-bit mode: upper strobe stays negated
// - Read: S0 codes, S1 address, S2 strobes
// - Read: latch, negate entering S7, float
// - Sample fault and peripheral on falling edges
// - Fault without acknowledge ends at S9
package cabc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ = 40000000;
    localparam int unsigned BUS_CLK_HZ = 10000000;
    // Each bus state is half a bus clock
    localparam int unsigned HALF_TICKS = SYS_CLK_HZ / (2 * BUS_CLK_HZ);
    localparam int DIV_W = 4;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_TICKS - 1);

    // ----------------------------------------------------------------
    // Bus states
    // ----------------------------------------------------------------
    localparam int STEP_W = 5;
    localparam logic [STEP_W-1:0] S0 = 5'h00;
    localparam logic [STEP_W-1:0] S1 = 5'h01;
    localparam logic [STEP_W-1:0] S2 = 5'h02;
    localparam logic [STEP_W-1:0] S3 = 5'h03;
    localparam logic [STEP_W-1:0] S4 = 5'h04;
    localparam logic [STEP_W-1:0] S5 = 5'h05;
    localparam logic [STEP_W-1:0] S7 = 5'h07;
    localparam logic [STEP_W-1:0] S8 = 5'h08;
    localparam logic [STEP_W-1:0] S9 = 5'h09;
    localparam logic [STEP_W-1:0] S12 = 5'h0C;
    localparam logic [STEP_W-1:0] S14 = 5'h0E;
    localparam logic [STEP_W-1:0] S15 = 5'h0F;
    localparam logic [STEP_W-1:0] S16 = 5'h10;
    localparam logic [STEP_W-1:0] S19 = 5'h13;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int FC_W = 3;
    localparam logic [FC_W-1:0] FC_RST = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [2:0] {
        CABC_IDLE = 3'b001,
        CABC_ARM = 3'b010,
        CABC_RUN = 3'b100
    } cabc_state_t;

    typedef struct packed {
        cabc_state_t st;
        logic [DIV_W-1:0] div;
        logic bus_clk;
        logic [STEP_W-1:0] step;
        logic mode16;
        logic is_write;
        logic is_rmw;
        logic is_word;
        logic split_pend;
        logic ack_seen;
        logic fault_seen;
        logic periph_seen;
        logic [ADDR_W-1:0] addr;
        logic [FC_W-1:0] fc;
        logic [DATA_W-1:0] wdata;
        logic sel_upper;
        logic sel_lower;
        logic addr_strobe_n;
        logic upper_strobe_n;
        logic lower_strobe_n;
        logic read_write;
        logic addr_oe_n;
        logic data_oe_n;
        logic [DATA_W-1:0] data_out;
        logic [DATA_W-1:0] rdata;
        logic req_ready;
        logic done;
        logic fault;
        logic periph;
        logic rmw_rd_valid;
    } cabc_regs_t;

endpackage : cabc_pkg

// file: logic/cabc_sequencer.sv
// Bus-master cycle sequencer for the asynchronous external bus.
`timescale 1ns/1ps
`default_nettype none
module cabc_sequencer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Bus width strap, sampled while reset is applied
    input wire logic bus_width_sel,
    // Request from the core
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_rmw,
    input wire logic req_word,
    input wire logic [cabc_pkg::ADDR_W-1:0] req_addr,
    input wire logic [cabc_pkg::FC_W-1:0] req_fc,
    input wire logic [cabc_pkg::DATA_W-1:0] req_wdata,
    input wire logic [7:0] rmw_mod_data,
    // Answer to the core
    output logic req_ready,
    output logic done,
    output logic fault,
    output logic periph,
    output logic rmw_rd_valid,
    output logic [cabc_pkg::DATA_W-1:0] rdata,
    output logic mode16,
    // External bus outputs
    output logic bus_clk,
    output logic [cabc_pkg::ADDR_W-1:0] addr_o,
    output logic addr_oe_n,
    output logic [cabc_pkg::DATA_W-1:0] data_o,
    output logic data_oe_n,
    output logic address_strobe_n,
    output logic upper_byte_strobe_n,
    output logic lower_byte_strobe_n,
    output logic read_write,
    output logic [cabc_pkg::FC_W-1:0] cycle_class_code,
    // External bus inputs
    input wire logic [cabc_pkg::DATA_W-1:0] data_i,
    input wire logic transfer_ack_n,
    input wire logic bus_fault_n,
    input wire logic slow_peripheral_req_n
);

    // ----------------------------------------
    // Reset image
    // ----------------------------------------
    localparam cabc_pkg::cabc_regs_t RST_IMAGE = '{
        st: cabc_pkg::CABC_IDLE,
        div: '0,
        bus_clk: 1'b0,
        step: cabc_pkg::S0,
        mode16: 1'b1,
        is_write: 1'b0,
        is_rmw: 1'b0,
        is_word: 1'b0,
        split_pend: 1'b0,
        ack_seen: 1'b0,
        fault_seen: 1'b0,
        periph_seen: 1'b0,
        addr: cabc_pkg::ADDR_RST,
        fc: cabc_pkg::FC_RST,
        wdata: cabc_pkg::DATA_RST,
        sel_upper: 1'b0,
        sel_lower: 1'b0,
        addr_strobe_n: 1'b1,
        upper_strobe_n: 1'b1,
        lower_strobe_n: 1'b1,
        read_write: 1'b1,
        addr_oe_n: 1'b1,
        data_oe_n: 1'b1,
        data_out: cabc_pkg::DATA_RST,
        rdata: cabc_pkg::DATA_RST,
        req_ready: 1'b0,
        done: 1'b0,
        fault: 1'b0,
        periph: 1'b0,
        rmw_rd_valid: 1'b0
    };

    cabc_pkg::cabc_regs_t q;
    cabc_pkg::cabc_regs_t d;

    // ----------------------------------------
    // Lane helpers
    // ----------------------------------------
    function automatic logic [cabc_pkg::DATA_W-1:0] write_lanes(
        input logic m16,
        input logic word,
        input logic a0,
        input logic [cabc_pkg::DATA_W-1:0] wd
    );
        logic [7:0] b;
        b = a0 ? wd[7:0] : wd[15:8];
        if (m16 && word) begin
            write_lanes = wd;
        end else if (m16) begin
            write_lanes = {wd[7:0], wd[7:0]};
        end else if (word) begin
            // Upper lines are driven to zero in narrow mode
            write_lanes = {cabc_pkg::BYTE_ZERO, b};
        end else begin
            write_lanes = {cabc_pkg::BYTE_ZERO, wd[7:0]};
        end
    endfunction : write_lanes

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic tick;
    logic wait_step;
    logic extend;
    logic rmw_cont;
    logic finish;
    logic [cabc_pkg::STEP_W-1:0] nx;

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.fault = 1'b0;
        d.periph = 1'b0;
        d.rmw_rd_valid = 1'b0;
        nx = q.step;
        finish = 1'b0;
        tick = (q.div == cabc_pkg::DIV_LAST);
        wait_step = (q.step == cabc_pkg::S4) || (q.step == cabc_pkg::S16);
        extend = q.fault_seen && !q.ack_seen;
        rmw_cont = q.is_rmw && q.ack_seen && !q.periph_seen && (q.step <= cabc_pkg::S7);

        d.div = tick ? '0 : q.div + 1'b1;
        if (tick) begin
            // Even states are the high half of the bus clock
            d.bus_clk = !q.bus_clk;
        end

        unique case (q.st)
            cabc_pkg::CABC_IDLE: begin
                d.req_ready = 1'b1;
                if (req_valid && q.req_ready) begin
                    d.req_ready = 1'b0;
                    d.st = cabc_pkg::CABC_ARM;
                    d.is_write = req_write || req_rmw;
                    d.is_rmw = req_rmw;
                    d.is_word = req_word && !req_rmw;
                    d.addr = req_addr;
                    d.fc = req_fc;
                    d.wdata = req_wdata;
                    d.rdata = cabc_pkg::DATA_RST;
                    // Narrow bus moves a word as two byte cycles, A0 low first
                    d.split_pend = !q.mode16 && req_word && !req_rmw;
                    if (!q.mode16 && req_word && !req_rmw) begin
                        d.addr[0] = 1'b0;
                    end
                end
            end
            cabc_pkg::CABC_ARM: begin
                // Start only on a rising bus clock edge
                if (tick && !q.bus_clk) begin
                    d.st = cabc_pkg::CABC_RUN;
                    d.step = cabc_pkg::S0;
                    d.read_write = 1'b1;
                    d.ack_seen = 1'b0;
                    d.fault_seen = 1'b0;
                    d.periph_seen = 1'b0;
                    if (!q.mode16) begin
                        d.sel_upper = 1'b0;
                        d.sel_lower = 1'b1;
                    end else if (q.is_word) begin
                        d.sel_upper = 1'b1;
                        d.sel_lower = 1'b1;
                    end else begin
                        d.sel_upper = !q.addr[0];
                        d.sel_lower = q.addr[0];
                    end
                end
            end
            cabc_pkg::CABC_RUN: begin
                if (tick) begin
                    nx = q.step + 1'b1;
                    // Falling edges from S4 on: fault sampled; peripheral only at S4 and S16
                    if (q.bus_clk && q.step >= cabc_pkg::S4) begin
                        if (!bus_fault_n) begin
                            d.fault_seen = 1'b1;
                        end
                    end
                    if (wait_step) begin
                        if (!transfer_ack_n || !bus_fault_n) begin
                            d.ack_seen = !transfer_ack_n;
                        end else if (!slow_peripheral_req_n) begin
                            // Hand the cycle over to the peripheral sequence
                            d.periph_seen = 1'b1;
                            nx = (q.step == cabc_pkg::S16) ? cabc_pkg::S19 : cabc_pkg::S7;
                        end else begin
                            // Whole-clock wait: back to the low half, no bus change
                            nx = q.step - 1'b1;
                        end
                    end
                    if (q.step == cabc_pkg::S19) begin
                        finish = 1'b1;
                    end else if (q.step == cabc_pkg::S9 && extend) begin
                        finish = 1'b1;
                    end else if (q.step == cabc_pkg::S7 && !extend && !rmw_cont) begin
                        finish = 1'b1;
                    end

                    if (finish) begin
                        // Rising edge at the end of the last state
                        d.addr_oe_n = 1'b1;
                        d.data_oe_n = 1'b1;
                        d.read_write = 1'b1;
                        d.addr_strobe_n = 1'b1;
                        d.upper_strobe_n = 1'b1;
                        d.lower_strobe_n = 1'b1;
                        d.step = cabc_pkg::S0;
                        if (q.split_pend && !q.fault_seen && !q.periph_seen) begin
                            d.split_pend = 1'b0;
                            d.addr[0] = 1'b1;
                            d.st = cabc_pkg::CABC_ARM;
                        end else begin
                            d.split_pend = 1'b0;
                            d.st = cabc_pkg::CABC_IDLE;
                            d.done = 1'b1;
                            d.fault = q.fault_seen && !q.ack_seen;
                            d.periph = q.periph_seen;
                        end
                    end else begin
                        d.step = nx;
                        unique case (nx)
                            cabc_pkg::S1: begin
                                d.addr_oe_n = 1'b0;
                            end
                            cabc_pkg::S2: begin
                                d.addr_strobe_n = 1'b0;
                                if (q.is_write && !q.is_rmw) begin
                                    d.read_write = 1'b0;
                                end else begin
                                    d.upper_strobe_n = !q.sel_upper;
                                    d.lower_strobe_n = !q.sel_lower;
                                end
                            end
                            cabc_pkg::S3: begin
                                if (q.is_write && !q.is_rmw && q.step == cabc_pkg::S2) begin
                                    d.data_oe_n = 1'b0;
                                    d.data_out = write_lanes(q.mode16, q.is_word, q.addr[0], q.wdata);
                                end
                            end
                            cabc_pkg::S4: begin
                                if (q.is_write && !q.is_rmw) begin
                                    d.upper_strobe_n = !q.sel_upper;
                                    d.lower_strobe_n = !q.sel_lower;
                                end
                            end
                            cabc_pkg::S7: begin
                                if (!q.is_write || q.is_rmw) begin
                                    // Read data is taken as S6 closes
                                    if (!q.mode16 && q.is_word) begin
                                        if (q.addr[0]) begin
                                            d.rdata[7:0] = data_i[7:0];
                                        end else begin
                                            d.rdata[15:8] = data_i[7:0];
                                        end
                                    end else if (q.is_word) begin
                                        d.rdata = data_i;
                                    end else begin
                                        d.rdata = {cabc_pkg::BYTE_ZERO,
                                            (q.mode16 && !q.addr[0]) ? data_i[15:8] : data_i[7:0]};
                                    end
                                    d.rmw_rd_valid = q.is_rmw && q.ack_seen;
                                end
                                // A lone fault keeps strobes one clock longer
                                if (!extend) begin
                                    d.upper_strobe_n = 1'b1;
                                    d.lower_strobe_n = 1'b1;
                                    if (!rmw_cont) begin
                                        d.addr_strobe_n = 1'b1;
                                    end
                                end
                            end
                            cabc_pkg::S9: begin
                                if (extend) begin
                                    d.addr_strobe_n = 1'b1;
                                    d.upper_strobe_n = 1'b1;
                                    d.lower_strobe_n = 1'b1;
                                end
                            end
                            cabc_pkg::S12: begin
                                // Write portion starts with the bus untouched
                                d.ack_seen = 1'b0;
                                d.fault_seen = 1'b0;
                            end
                            cabc_pkg::S14: begin
                                d.read_write = 1'b0;
                            end
                            cabc_pkg::S15: begin
                                if (q.step == cabc_pkg::S14) begin
                                    d.data_oe_n = 1'b0;
                                    d.data_out = write_lanes(q.mode16, 1'b0, q.addr[0],
                                        {cabc_pkg::BYTE_ZERO, rmw_mod_data});
                                end
                            end
                            cabc_pkg::S16: begin
                                d.upper_strobe_n = !q.sel_upper;
                                d.lower_strobe_n = !q.sel_lower;
                            end
                            cabc_pkg::S19: begin
                                d.addr_strobe_n = 1'b1;
                                d.upper_strobe_n = 1'b1;
                                d.lower_strobe_n = 1'b1;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
            end
            default: begin
                d = RST_IMAGE;
            end
        endcase
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            q <= RST_IMAGE;
            // Strap is caught while reset is held
            q.mode16 <= bus_width_sel;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign req_ready = q.req_ready;
    assign done = q.done;
    assign fault = q.fault;
    assign periph = q.periph;
    assign rmw_rd_valid = q.rmw_rd_valid;
    assign rdata = q.rdata;
    assign mode16 = q.mode16;
    assign bus_clk = q.bus_clk;
    // Wide mode never presents A0 on the bus
    assign addr_o = q.addr & {{(cabc_pkg::ADDR_W-1){1'b1}}, !q.mode16};
    assign addr_oe_n = q.addr_oe_n;
    assign data_o = q.data_out;
    assign data_oe_n = q.data_oe_n;
    assign address_strobe_n = q.addr_strobe_n;
    assign upper_byte_strobe_n = q.upper_strobe_n;
    assign lower_byte_strobe_n = q.lower_strobe_n;
    assign read_write = q.read_write;
    assign cycle_class_code = q.fc;

endmodule : cabc_sequencer
`default_nettype wire

// file: bench/cabc_assertions.sv
// Port-level assertions for the bus cycle sequencer.
`timescale 1ns/1ps
`default_nettype none
module cabc_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Core side
    input wire logic mode16,
    input wire logic done,
    input wire logic fault,
    input wire logic rmw_rd_valid,
    // Bus side
    input wire logic [23:0] addr_o,
    input wire logic addr_oe_n,
    input wire logic data_oe_n,
    input wire logic address_strobe_n,
    input wire logic upper_byte_strobe_n,
    input wire logic lower_byte_strobe_n,
    input wire logic read_write,
    input wire logic transfer_ack_n,
    input wire logic bus_fault_n,
    input wire logic slow_peripheral_req_n
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    wire logic ds_lo = !upper_byte_strobe_n || !lower_byte_strobe_n;
    property p_reset_idle;
        $fell(sys_rst) |-> address_strobe_n && !ds_lo && data_oe_n;
    endproperty
    property p_write_low;
        $fell(read_write) |-> !address_strobe_n;
    endproperty
    property p_write_data;
        !read_write && ds_lo |-> !data_oe_n;
    endproperty
    property p_upper_idle;
        !mode16 |-> upper_byte_strobe_n;
    endproperty
    property p_word_addr;
        mode16 && !addr_oe_n |-> !addr_o[0];
    endproperty
    property p_end_float;
        done |-> addr_oe_n && data_oe_n && read_write && address_strobe_n;
    endproperty
    property p_wait;
        ds_lo && transfer_ack_n && bus_fault_n && slow_peripheral_req_n |=> !address_strobe_n;
    endproperty
    property p_ds_with_as;
        ds_lo |-> !address_strobe_n;
    endproperty
    property p_rmw_hold;
        rmw_rd_valid |-> (!address_strobe_n && !ds_lo) ##1 !address_strobe_n [*7];
    endproperty
    property p_fault_late;
        fault |-> done && !$past(bus_fault_n, 2) && $past(transfer_ack_n, 2);
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("strobe or data active after reset");
    a_write_low: assert property (p_write_low) else $error("write level without address strobe");
    a_write_data: assert property (p_write_data) else $error("write strobe without data driven");
    a_upper_idle: assert property (p_upper_idle) else $error("upper strobe in byte mode");
    a_word_addr: assert property (p_word_addr) else $error("lowest address bit set in word mode");
    a_end_float: assert property (p_end_float) else $error("bus not released at cycle end");
    a_wait: assert property (p_wait) else $error("cycle ended without an answer");
    a_ds_with_as: assert property (p_ds_with_as) else $error("data strobe without address strobe");
    a_rmw_hold: assert property (p_rmw_hold) else $error("address strobe dropped in locked cycle");
    a_fault_late: assert property (p_fault_late) else $error("fault result without fault answer");
    c_fault: cover property (fault);
    c_rmw: cover property (rmw_rd_valid);
    c_narrow: cover property (done && !mode16);
endmodule : cabc_assertions
bind cabc_sequencer cabc_assertions chk_u (.*);
`default_nettype wire

// file: bench/cabc_slave_model.sv
// Behavioural slave memory answering the sequencer's bus cycles.
`timescale 1ns/1ps
`default_nettype none
module cabc_slave_model (
    // Clock and bench control
    input wire logic clk_sys,
    input wire logic bus_width_sel,
    input wire logic [1:0] kind,
    input wire logic [3:0] waits,
    // Bus from the sequencer
    input wire logic [23:0] addr_o,
    input wire logic [15:0] data_o,
    input wire logic upper_byte_strobe_n,
    input wire logic lower_byte_strobe_n,
    input wire logic read_write,
    // Answers
    output logic [15:0] data_i,
    output logic transfer_ack_n,
    output logic bus_fault_n,
    output logic slow_peripheral_req_n
);
    logic [7:0] mem [256];
    int cnt = 0;
    wire logic sel = !upper_byte_strobe_n || !lower_byte_strobe_n;
    wire logic [7:0] up = {addr_o[7:1], 1'b0};
    wire logic [7:0] lo = bus_width_sel ? {addr_o[7:1], 1'b1} : addr_o[7:0];
    initial begin
        data_i = 16'h0000;
        transfer_ack_n = 1'b1;
        bus_fault_n = 1'b1;
        slow_peripheral_req_n = 1'b1;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i * 7 + 3);
    end
    always @(posedge clk_sys) begin
        if (!sel) begin
            cnt <= 0;
            transfer_ack_n <= 1'b1;
            bus_fault_n <= 1'b1;
            slow_peripheral_req_n <= 1'b1;
        end else if (cnt < int'(waits)) begin
            cnt <= cnt + 1;
        end else begin
            transfer_ack_n <= kind != 2'h0;
            bus_fault_n <= kind != 2'h1;
            slow_peripheral_req_n <= kind != 2'h2;
            if (kind == 2'h0 && !read_write && !upper_byte_strobe_n)
                mem[up] <= data_o[15:8];
            if (kind == 2'h0 && !read_write && !lower_byte_strobe_n)
                mem[lo] <= data_o[7:0];
        end
        // Released lines toggle so stale data is never taken as valid
        if (sel && read_write)
            data_i <= {mem[up], mem[lo]};
        else
            data_i <= ~data_i;
    end
endmodule : cabc_slave_model
`default_nettype wire

// file: bench/cabc_sequencer_test.sv
// Self-checking bench for the bus cycle sequencer.
`timescale 1ns/1ps
`default_nettype none
module cabc_sequencer_test;
    logic clk_sys = 1'b0, sys_rst = 1'b1, bus_width_sel = 1'b1, req_valid = 1'b0;
    logic req_write = 1'b0, req_rmw = 1'b0, req_word = 1'b0;
    logic [23:0] req_addr = 24'h000000;
    logic [2:0] req_fc = 3'h0;
    logic [15:0] req_wdata = 16'h0000;
    logic [7:0] rmw_mod_data = 8'h00;
    logic [1:0] kind = 2'h0;
    logic [3:0] waits = 4'h0;
    logic req_ready, done, fault, periph, rmw_rd_valid, mode16, bus_clk, addr_oe_n, data_oe_n;
    logic address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, read_write;
    logic transfer_ack_n, bus_fault_n, slow_peripheral_req_n;
    logic [15:0] rdata, data_o, data_i;
    logic [23:0] addr_o;
    logic [2:0] cycle_class_code;
    logic [7:0] ref_mem [256];
    int n_fail = 0, check_count = 0, cyc = 0;
    cabc_sequencer dut_u (.*);
    cabc_slave_model mem_u (.*);
    always #12.5 clk_sys = ~clk_sys;
    task automatic check(input string nm, input logic [23:0] exp, got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic do_reset(input logic w);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        bus_width_sel <= w;
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        check("mode16", 24'(w), 24'(mode16));
    endtask : do_reset
    task automatic op(input logic w, m, wd, input logic [7:0] a, input logic [1:0] k);
        logic [15:0] d = 16'($urandom);
        logic [2:0] fc = 3'($urandom);
        logic [7:0] rv = 8'h00;
        logic pv = 1'b1, su = 1'b0, sl = 1'b0;
        int nas = 0;
        do
            @(negedge clk_sys);
        while (req_ready !== 1'b1);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_write <= w;
        req_rmw <= m;
        req_word <= wd;
        req_addr <= {16'($urandom), a};
        req_fc <= fc;
        req_wdata <= d;
        rmw_mod_data <= 8'($urandom);
        kind <= k;
        waits <= 4'($urandom_range(9));
        @(posedge clk_sys);
        req_valid <= 1'b0;
        do begin
            @(negedge clk_sys);
            if (pv && !address_strobe_n)
                check("bus_clk", 24'h1, 24'(bus_clk));
            nas += int'(pv && !address_strobe_n);
            pv = address_strobe_n;
            su |= !upper_byte_strobe_n;
            sl |= !lower_byte_strobe_n;
            if (rmw_rd_valid === 1'b1)
                rv = rdata[7:0];
            if (!address_strobe_n) begin
                check("class", 24'(fc), 24'(cycle_class_code));
                check("addr", 24'(req_addr[23:1]), 24'(addr_o[23:1]));
            end
        end while (done !== 1'b1);
        check("fault", 24'(k == 2'h1), 24'(fault));
        check("periph", 24'(k == 2'h2), 24'(periph));
        check("cycles", (!bus_width_sel && wd && k == 2'h0) ? 24'h2 : 24'h1, 24'(nas));
        check("upper", 24'(bus_width_sel && (wd || !a[0])), 24'(su));
        check("lower", 24'(!bus_width_sel || wd || a[0]), 24'(sl));
        if (k == 2'h0) begin
            if (m) begin
                check("rmw_read", 24'(ref_mem[a]), 24'(rv));
                ref_mem[a] = rmw_mod_data;
            end else if (w && wd) begin
                ref_mem[a] = d[15:8];
                ref_mem[a + 8'h01] = d[7:0];
            end else if (w) begin
                ref_mem[a] = d[7:0];
            end else if (wd) begin
                check("rdata", 24'({ref_mem[a], ref_mem[a + 8'h01]}), 24'(rdata));
            end else begin
                check("rbyte", 24'(ref_mem[a]), 24'(rdata[7:0]));
            end
        end
    endtask : op
    initial begin
        logic [7:0] a;
        for (int i = 0; i < 256; i++)
            ref_mem[i] = 8'(i * 7 + 3);
        void'($urandom(27));
        for (int md = 1; md >= 0; md--) begin
            do_reset(md[0]);
            for (int i = 0; i < 24; i++) begin
                a = 8'($urandom);
                op(1'b1, 1'b0, 1'b1, a & 8'hFE, 2'h0);
                op(1'b0, 1'b0, 1'b1, a & 8'hFE, 2'h0);
                op(1'b1, 1'b0, 1'b0, a, 2'h0);
                op(1'b0, 1'b0, 1'b0, a ^ 8'h01, 2'h0);
                op(1'b0, 1'b1, 1'b0, a, 2'h0);
                op(1'b0, 1'b0, i[0], a & 8'hFE, 2'h1);
                op(1'b1, 1'b0, 1'b0, a, 2'h2);
                op(1'b0, 1'b0, 1'b0, a, 2'h0);
            end
        end
        wrap_up();
    end
endmodule : cabc_sequencer_test
`default_nettype wire
